// >>> core/park_ctrl_pkg.sv
// Purpose: shared constants and carriers for the reset and mirror-park control block
// Assumes: a single 20 MHz controller clock
// Notes: times are kept in their own unit and turned into cycle counts here
`default_nettype none
package park_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and time
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20_000_000;
  localparam int FAST_PARK_LIMIT_US = 40;
  // longest time, so rounded down
  localparam int FAST_PARK_LIMIT_CYCLES = (FAST_PARK_LIMIT_US * CLOCK_HZ) / 1_000_000;
  // our fast park uses half the limit, leaving room for input filtering
  localparam int FAST_PARK_RUN_CYCLES = FAST_PARK_LIMIT_CYCLES / 2;
  localparam int NORMAL_PARK_MS = 20;
  localparam int NORMAL_PARK_CYCLES = (NORMAL_PARK_MS * CLOCK_HZ) / 1_000;
  localparam int CONFIG_CYCLES = 256;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

  // ----------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RESET       = 6'h01,
    ST_CONFIG      = 6'h02,
    ST_RUN         = 6'h04,
    ST_NORMAL_PARK = 6'h08,
    ST_FAST_PARK   = 6'h10,
    ST_PARKED      = 6'h20
  } park_state_t;

  // ----------------------------------------------------------------
  // pins released to high impedance during reset
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flash_serial_clock;
    logic flash_serial_dout;
    logic flash_select_a_low;
    logic flash_select_b_low;
    logic power_chip_serial_clock;
    logic power_chip_select_low;
    logic power_chip_serial_din;
    logic power_chip_serial_dout;
    logic trigger_output_a;
    logic trigger_output_b;
    logic [14:0] general_pins_upper;
  } float_pins_t;

  // pins forced low during reset while their I/O power is present
  typedef struct packed {
    logic light_select_a;
    logic light_select_b;
    logic mirror_enable_reset_low;
  } forced_pins_t;

endpackage
`default_nettype wire

// >>> core/reset_and_mirror_park_control.sv
// Purpose: power-on reset handling, self-configuration start and mirror park sequencing
// Assumes: power-on reset and park inputs arrive asynchronously from outside parties
// Notes: the pin-level gating by power-on reset is combinational so pins float at once
`default_nettype none
module reset_and_mirror_park_control
  import park_ctrl_pkg::*;
#(
  parameter int NORMAL_PARK_LEN = NORMAL_PARK_CYCLES
)(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // control pins from the power chip and host
  input wire logic I_POWER_ON_RESET_LOW,
  input wire logic I_FAST_PARK_REQUEST_LOW,
  input wire logic I_NORMAL_PARK_REQUEST_LOW,
  input wire logic I_IO_SUPPLY_OK,
  // values from the datapath logic for the floating and forced groups
  input wire float_pins_t I_FLOAT_DATA,
  input wire float_pins_t I_FLOAT_OE,
  input wire forced_pins_t I_FORCED_DATA,
  // floating group pins
  output logic [$bits(float_pins_t)-1:0] O_FLOAT_DATA,
  output logic [$bits(float_pins_t)-1:0] O_FLOAT_OE,
  // forced-low group pins
  output logic [$bits(forced_pins_t)-1:0] O_FORCED_DATA,
  output logic [$bits(forced_pins_t)-1:0] O_FORCED_OE,
  // host interrupt pin
  output logic O_HOST_IRQ,
  output logic O_HOST_IRQ_OE,
  // status
  output logic O_CONFIG_BUSY,
  output logic O_RUNNING,
  output logic O_PARK_BUSY,
  output logic O_PARKED
);

  // ----------------------------------------------------------------
  // input filtering
  // ----------------------------------------------------------------
  logic [2:0] por_sync_q;
  logic [2:0] fast_sync_q;
  logic [2:0] norm_sync_q;
  logic por_q;
  logic fast_q;
  logic norm_q;
  logic por_d;
  logic fast_d;
  logic norm_d;

  // a level counts only once the second and third stages agree
  assign por_d = (por_sync_q[1] == por_sync_q[2]) ? por_sync_q[2] : por_q;
  assign fast_d = (fast_sync_q[1] == fast_sync_q[2]) ? fast_sync_q[2] : fast_q;
  assign norm_d = (norm_sync_q[1] == norm_sync_q[2]) ? norm_sync_q[2] : norm_q;

  // three-stage synchronisers, all inputs start at the asserted (low) level
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      por_sync_q <= SYNC_RESET;
      fast_sync_q <= SYNC_RESET;
      norm_sync_q <= SYNC_RESET;
    end
    else
    begin
      por_sync_q <= {por_sync_q[1:0], I_POWER_ON_RESET_LOW};
      fast_sync_q <= {fast_sync_q[1:0], I_FAST_PARK_REQUEST_LOW};
      norm_sync_q <= {norm_sync_q[1:0], I_NORMAL_PARK_REQUEST_LOW};
    end
  end

  // filtered levels
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      por_q <= 1'b0;
      fast_q <= 1'b0;
      norm_q <= 1'b0;
    end
    else
    begin
      por_q <= por_d;
      fast_q <= fast_d;
      norm_q <= norm_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CONFIG_LAST = CNT_W'(CONFIG_CYCLES - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_PARK_RUN_CYCLES - 1);
  localparam logic [CNT_W-1:0] NORMAL_LAST = CNT_W'(NORMAL_PARK_LEN - 1);

  park_state_t state_q;
  park_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic por_rise;
  logic config_done;
  logic fast_done;
  logic normal_done;
  logic run_ok;

  assign por_rise = por_d & ~por_q;
  assign config_done = (cnt_q == CONFIG_LAST);
  assign fast_done = (cnt_q == FAST_LAST);
  assign normal_done = (cnt_q == NORMAL_LAST);
  // normal operation needs fast park released and no park request
  assign run_ok = fast_q & norm_q;

  // next state; loss of power-on reset overrides every other state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + CNT_W'(1);
    case (state_q)
      ST_RESET:
      begin
        cnt_d = CNT_RESET;
        if (por_rise)
          state_d = ST_CONFIG;
      end
      ST_CONFIG:
      begin
        if (!fast_q)
        begin
          state_d = ST_FAST_PARK;
          cnt_d = CNT_RESET;
        end
        else if (config_done)
        begin
          state_d = ST_PARKED;
          cnt_d = CNT_RESET;
        end
      end
      ST_RUN:
      begin
        cnt_d = CNT_RESET;
        if (!fast_q)
          state_d = ST_FAST_PARK;
        else if (!norm_q)
          state_d = ST_NORMAL_PARK;
      end
      ST_NORMAL_PARK:
      begin
        if (!fast_q)
        begin
          // abandon the slow park, fast park starts from zero
          state_d = ST_FAST_PARK;
          cnt_d = CNT_RESET;
        end
        else if (normal_done)
        begin
          state_d = ST_PARKED;
          cnt_d = CNT_RESET;
        end
      end
      ST_FAST_PARK:
      begin
        if (fast_done)
        begin
          state_d = ST_PARKED;
          cnt_d = CNT_RESET;
        end
      end
      ST_PARKED:
      begin
        cnt_d = CNT_RESET;
        if (run_ok)
          state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RESET;
        cnt_d = CNT_RESET;
      end
    endcase
    // uses the next filtered level so the rising edge itself is not overridden
    if (!por_d)
    begin
      state_d = ST_RESET;
      cnt_d = CNT_RESET;
    end
  end

  // state and counter
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state_q <= ST_RESET;
      cnt_q <= CNT_RESET;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  float_pins_t float_data_q;
  forced_pins_t forced_data_q;
  logic irq_q;
  logic in_reset;
  logic active_ok;
  logic running;

  assign running = (state_q == ST_RUN);
  // the raw pin gates outputs so they let go without filter delay
  assign in_reset = (state_q == ST_RESET) | ~I_POWER_ON_RESET_LOW;
  assign active_ok = ~in_reset;

  // registered pin values; mirrors and light only enabled while running
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      float_data_q <= '0;
      forced_data_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      float_data_q <= I_FLOAT_DATA;
      forced_data_q <= running ? I_FORCED_DATA : '0;
      // low while configuring, high once done
      irq_q <= (state_q != ST_CONFIG) & (state_q != ST_RESET);
    end
  end

  // floating group released during reset
  assign O_FLOAT_DATA = active_ok ? float_data_q : '0;
  assign O_FLOAT_OE = active_ok ? I_FLOAT_OE : '0;
  // forced group drives low in reset while its I/O power is present
  assign O_FORCED_DATA = active_ok ? forced_data_q : '0;
  assign O_FORCED_OE = {$bits(forced_pins_t){active_ok | I_IO_SUPPLY_OK}};
  // interrupt floats during reset, an external pullup defines it
  assign O_HOST_IRQ = active_ok & irq_q;
  assign O_HOST_IRQ_OE = active_ok;

  // status outputs
  assign O_CONFIG_BUSY = (state_q == ST_CONFIG);
  assign O_RUNNING = running & I_POWER_ON_RESET_LOW;
  assign O_PARK_BUSY = (state_q == ST_NORMAL_PARK) | (state_q == ST_FAST_PARK);
  assign O_PARKED = (state_q == ST_PARKED);

endmodule
`default_nettype wire

// >>> dv/park_asserts.sv
// Purpose: checker for reset gating, configuration start and park timing
// Assumes: one clock domain, reset asynchronous and active low
// Notes: busy lengths are counted in helper logic
`default_nettype none
module park_asserts
  import park_ctrl_pkg::*;
#(
  parameter int NORMAL_PARK_LEN = NORMAL_PARK_CYCLES
)(
  // clock, reset and pins
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_POWER_ON_RESET_LOW,
  input wire logic I_FAST_PARK_REQUEST_LOW,
  input wire logic I_NORMAL_PARK_REQUEST_LOW,
  input wire logic I_IO_SUPPLY_OK,
  // watched outputs
  input wire logic [$bits(float_pins_t)-1:0] O_FLOAT_DATA,
  input wire logic [$bits(float_pins_t)-1:0] O_FLOAT_OE,
  input wire logic [2:0] O_FORCED_DATA,
  input wire logic [2:0] O_FORCED_OE,
  input wire logic O_HOST_IRQ,
  input wire logic O_HOST_IRQ_OE,
  input wire logic O_CONFIG_BUSY,
  input wire logic O_RUNNING,
  input wire logic O_PARK_BUSY,
  input wire logic O_PARKED
);
  // ----
  // busy counters, cleared when idle so each run is judged alone
  // ----
  logic [19:0] cfg_q;
  logic [19:0] park_q;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      cfg_q <= 20'h0;
      park_q <= 20'h0;
    end
    else
    begin
      cfg_q <= O_CONFIG_BUSY ? cfg_q + 20'h1 : 20'h0;
      park_q <= O_PARK_BUSY ? park_q + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_ARST_N);
  // fast park taken while running or parking slowly
  sequence fast_drop_s;
    $fell(I_FAST_PARK_REQUEST_LOW) && I_POWER_ON_RESET_LOW && (O_RUNNING || O_PARK_BUSY);
  endsequence
  sequence config_end_s;
    $fell(O_CONFIG_BUSY) && O_PARKED;
  endsequence
  a_float_released: assert property (!I_POWER_ON_RESET_LOW |-> O_FLOAT_OE == '0)
    else $error("float group driven in reset");
  a_forced_low: assert property (!I_POWER_ON_RESET_LOW && I_IO_SUPPLY_OK |->
    O_FORCED_OE == 3'h7 && O_FORCED_DATA == 3'h0) else $error("forced group not low");
  a_outputs_idle: assert property (!I_POWER_ON_RESET_LOW |->
    O_FLOAT_DATA == '0 && !O_HOST_IRQ) else $error("output active in reset");
  a_irq_floats: assert property (!I_POWER_ON_RESET_LOW |-> !O_HOST_IRQ_OE)
    else $error("irq driven in reset");
  a_config_start: assert property ($rose(I_POWER_ON_RESET_LOW) |-> ##[1:6] O_CONFIG_BUSY)
    else $error("configuration did not start");
  a_config_length: assert property (config_end_s |-> cfg_q == 20'h100)
    else $error("configuration length wrong");
  a_irq_done: assert property (config_end_s |-> ##[1:2] O_HOST_IRQ)
    else $error("irq did not show done");
  a_fast_in_time: assert property (fast_drop_s |-> ##[1:800] O_PARKED)
    else $error("fast park too slow");
  a_run_needs_fast: assert property (!I_FAST_PARK_REQUEST_LOW [*8] |-> !O_RUNNING)
    else $error("running with fast park low");
  a_normal_start: assert property ($fell(I_NORMAL_PARK_REQUEST_LOW) && O_RUNNING |->
    ##[1:8] O_PARK_BUSY) else $error("normal park not started");
  a_normal_length: assert property ($fell(O_PARK_BUSY) && O_PARKED |->
    park_q <= NORMAL_PARK_LEN) else $error("park too long");
endmodule
bind reset_and_mirror_park_control park_asserts #(.NORMAL_PARK_LEN(NORMAL_PARK_LEN))
  i_park_asserts (.*);
`default_nettype wire

// >>> dv/host_model.sv
// Purpose: power chip and host driving the reset and park pins
// Assumes: pins change only at the falling clock edge
// Notes: the normal park hold time is scaled down to keep the run short; fast park holds the full 40 us
`default_nettype none
module host_model #(
  parameter int HOLD = 20
)(
  // pacing clock
  input wire logic i_clk,
  // pins toward the block
  output logic o_por_low,
  output logic o_fast_low,
  output logic o_normal_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // supplies off at start; no serial traffic is ever sent, so the quiet time holds
  initial
  begin
    o_por_low = 1'b0;
    o_fast_low = 1'b0;
    o_normal_low = 1'b1;
  end
  // supplies and clock settle, then fast park goes high before reset rises
  task power_up();
    repeat (4) @(negedge i_clk);
    o_fast_low = 1'b1;
    repeat (2) @(negedge i_clk);
    o_por_low = 1'b1;
  endtask
  // power chip pulls reset low again while the clock keeps running
  task drop_reset();
    o_por_low = 1'b0;
  endtask
  // ordinary shutdown keeps reset high; each level is held before it may change
  task normal_park(input logic lvl);
    o_normal_low = lvl;
    repeat (HOLD) @(negedge i_clk);
  endtask
  // a fast park stays low for the full 40 us before power may go
  task fast_park(input logic lvl);
    o_fast_low = lvl;
    if (!lvl)
      repeat (800) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the reset and mirror-park control block
// Assumes: 20 MHz clock, inputs changed at the falling edge
// Notes: normal park shortened to 1000 cycles
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import park_ctrl_pkg::*;
  localparam int NPL = 1000;
  logic I_CLOCK = 1'b0;
  logic I_ARST_N, I_IO_SUPPLY_OK;
  wire I_POWER_ON_RESET_LOW, I_FAST_PARK_REQUEST_LOW, I_NORMAL_PARK_REQUEST_LOW;
  float_pins_t I_FLOAT_DATA, I_FLOAT_OE;
  forced_pins_t I_FORCED_DATA;
  logic [24:0] O_FLOAT_DATA, O_FLOAT_OE;
  logic [2:0] O_FORCED_DATA, O_FORCED_OE;
  logic O_HOST_IRQ, O_HOST_IRQ_OE, O_CONFIG_BUSY, O_RUNNING, O_PARK_BUSY, O_PARKED;
  int n_mismatch = 0;
  int checked = 0;
  // 50 ns period
  always #25 I_CLOCK = ~I_CLOCK;
  reset_and_mirror_park_control #(.NORMAL_PARK_LEN(NPL)) i_reset_and_mirror_park_control (.*);
  host_model i_host_model (
    .i_clk(I_CLOCK),
    .o_por_low(I_POWER_ON_RESET_LOW),
    .o_fast_low(I_FAST_PARK_REQUEST_LOW),
    .o_normal_low(I_NORMAL_PARK_REQUEST_LOW)
  );
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait on a status bit: 3 config, 2 parked, 1 running, 0 park busy
  task automatic wait_for(input int sel, input int lim, output int n);
    logic [3:0] st;
    n = 0;
    do
    begin
      @(negedge I_CLOCK);
      st = {O_CONFIG_BUSY, O_PARKED, O_RUNNING, O_PARK_BUSY};
      n++;
      if (n > lim)
      begin
        n_mismatch++;
        conclude();
      end
    end while (st[sel] !== 1'b1);
  endtask
  // datapath asks to drive everything, yet reset must win
  task automatic t_reset_pins();
    @(negedge I_CLOCK);
    check(O_FLOAT_OE, 32'h0);
    check({O_FORCED_OE, O_FORCED_DATA}, 32'h38);
    check({O_FLOAT_DATA, O_HOST_IRQ, O_HOST_IRQ_OE}, 32'h0);
    I_IO_SUPPLY_OK = 1'b0;
    @(negedge I_CLOCK);
    check(O_FORCED_OE, 32'h0);
    I_IO_SUPPLY_OK = 1'b1;
  endtask
  task automatic t_power_up();
    int n;
    i_host_model.power_up();
    wait_for(3, 8, n);
    check({O_HOST_IRQ, O_HOST_IRQ_OE}, 32'h1);
    wait_for(2, 300, n);
    check(n, 32'd256);
    wait_for(1, 4, n);
    @(negedge I_CLOCK);
    check(O_HOST_IRQ, 32'h1);
    check({O_FLOAT_DATA, O_FORCED_DATA}, {I_FLOAT_DATA, I_FORCED_DATA});
  endtask
  task automatic t_normal_park();
    int n;
    i_host_model.normal_park(1'b0);
    check(O_PARK_BUSY, 32'h1);
    wait_for(2, NPL, n);
    check({O_RUNNING, O_FORCED_DATA}, 32'h0);
    i_host_model.normal_park(1'b1);
    wait_for(1, 10, n);
  endtask
  // fast park overtakes a normal park already under way
  task automatic t_fast_abort();
    int n;
    i_host_model.normal_park(1'b0);
    i_host_model.fast_park(1'b0);
    check(O_PARKED, 32'h1);
    i_host_model.normal_park(1'b1);
    check(O_RUNNING, 32'h0);
    i_host_model.fast_park(1'b1);
    wait_for(1, 10, n);
  endtask
  // reset lost while running floats pins at once, then a fresh start and a fast park
  task automatic t_por_drop();
    int n;
    I_FLOAT_OE = ~I_FLOAT_DATA;
    @(negedge I_CLOCK);
    check(O_FLOAT_OE, I_FLOAT_OE);
    check(O_FORCED_OE, 32'h7);
    i_host_model.drop_reset();
    @(negedge I_CLOCK);
    check({O_FLOAT_OE, O_HOST_IRQ_OE, O_RUNNING}, 32'h0);
    check({O_FORCED_OE, O_FORCED_DATA}, 32'h38);
    repeat (6) @(negedge I_CLOCK);
    check({O_PARKED, O_PARK_BUSY, O_CONFIG_BUSY}, 32'h0);
    i_host_model.power_up();
    wait_for(3, 8, n);
    wait_for(2, 300, n);
    check(n, 32'd256);
    wait_for(1, 4, n);
    i_host_model.fast_park(1'b0);
    check({O_PARKED, O_FORCED_DATA}, 32'h8);
    i_host_model.fast_park(1'b1);
    wait_for(1, 10, n);
  endtask
  initial
  begin
    I_ARST_N = 1'b0;
    I_IO_SUPPLY_OK = 1'b1;
    I_FLOAT_DATA = 25'h1ffffff;
    I_FLOAT_OE = 25'h1ffffff;
    I_FORCED_DATA = 3'h7;
    repeat (3) @(negedge I_CLOCK);
    I_ARST_N = 1'b1;
    t_reset_pins();
    I_FLOAT_DATA = 25'h1a5a5a5;
    I_FORCED_DATA = 3'h5;
    t_power_up();
    t_normal_park();
    t_fast_abort();
    t_por_drop();
    conclude();
  end
endmodule
`default_nettype wire
